// ### logic/ucpc_pkg.sv
// package for the upgrade cpu pin control block
// assumes one 10 MHz bus clock and an active-low asynchronous reset
package ucpc_pkg;

  // ==========================================================
  // address layout
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 30;
  localparam int WRAP_BIT = 20;
  localparam int WRAP_IDX = WRAP_BIT - ADDR_LSB;
  localparam int LOW_PAIR_W = 2;
  localparam int UPPER_W = 28;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int BE_W = 4;

  // ==========================================================
  // asynchronous input vector layout
  localparam int NUM_ASYNC = 8;
  localparam int SYNC_STAGES = 2;
  localparam int AS_SOFT_RESET = 0;
  localparam int AS_IRQ = 1;
  localparam int AS_NMI = 2;
  localparam int AS_FLUSH_N = 3;
  localparam int AS_WRAP_N = 4;
  localparam int AS_SYS_IRQ_N = 5;
  localparam int AS_STOP_N = 6;
  localparam int AS_IGNORE_ERR_N = 7;
  // active-high lines idle at 0, active-low lines idle at 1
  localparam logic [NUM_ASYNC-1:0] ASYNC_RESET = 8'hF8;

  // ==========================================================
  // reset values of the pin state
  localparam logic [ADDR_W-1:0] ADDR_RESET = 30'h0;
  localparam logic [BE_W-1:0] BE_N_RESET = 4'hF;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0;
  localparam logic [PAR_W-1:0] PAR_RESET = 4'h0;
  localparam logic [UPPER_W-1:0] SNOOP_RESET = 28'h0;

  // ==========================================================
  // registered pin state
  typedef struct packed {
    logic bus_hold;
    logic addr_hold;
    logic snoop_n;
    logic backoff_n;
    logic size_sixteen_n;
    logic size_eight_n;
    logic cacheable_n;
    logic ready_n;
    logic burst_ready_n;
    logic [ADDR_W-1:0] cache_addr;
    logic [ADDR_W-1:0] bus_addr;
    logic [BE_W-1:0] be_n;
    logic write_through;
    logic cache_disable;
    logic w_r;
    logic d_c;
    logic m_io;
    logic lock_n;
    logic pseudo_lock_n;
    logic addr_strobe_n;
    logic burst_last_n;
    logic [DATA_W-1:0] data;
    logic [PAR_W-1:0] parity;
    logic drive_data;
    logic [DATA_W-1:0] data_pin;
    logic [UPPER_W-1:0] addr_pin;
  } ucpc_state_s;

endpackage

// ### logic/ucpc_sync.sv
// two-stage level synchroniser bank for the asynchronous pins
// assumes each line is a slow level held for at least two clocks
`timescale 1ns/10ps
module ucpc_sync (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // lines
  input wire logic [ucpc_pkg::NUM_ASYNC-1:0] async_in,
  output logic [ucpc_pkg::NUM_ASYNC-1:0] sync_out
);
  import ucpc_pkg::*;

  typedef struct packed {
    logic [NUM_ASYNC-1:0] meta;
    logic [NUM_ASYNC-1:0] stable;
  } ucpc_sync_s;

  ucpc_sync_s st;
  ucpc_sync_s next_st;

  // ==========================================================
  // per-line stages; the first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < NUM_ASYNC; g++) begin : g_line
      always_comb begin
        next_st.meta[g] = async_in[g];
        next_st.stable[g] = st.meta[g];
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '{meta: ASYNC_RESET, stable: ASYNC_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stable;

  property p_two_stage;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      $past(async_in, 2) == sync_out;
  endproperty
  a_two_stage: assert property (p_two_stage) else $error("sync delay not two clocks");

endmodule // ucpc_sync

// ### logic/ucpc_pin_ctrl.sv
// pin control of the upgrade processor: wrap masking, present pin,
// float control under hold, and sampling of synchronous and asynchronous inputs
// assumes core-side inputs and synchronous pins are on core_clk_in; only the asynchronous pin inputs are outside it
//
// Functional notes
// - wrap mask low forces address bit 20 zero for cache lookups and memory cycles.
// - wrap mask is asynchronous and its level is recognised every clock.
// - upgrade-present output is driven low always and never floated.
// - byte enables, locks, strobe, burst last, page and cycle pins float in bus hold.
// - address low pair and upper bits float in bus hold or address hold.
// - data and parity lines float in bus hold only, not address hold.
// - hold, address hold, snoop, backoff, size, cacheable, ready pins sampled synchronously.
// - reset, soft reset, interrupts, flush, wrap, mgmt irq, stop, ignore error are asynchronous.
// - page write-through and cache-disable share the cycle definition timing.
`timescale 1ns/10ps
module ucpc_pin_ctrl (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // core side cycle request
  input wire logic [ucpc_pkg::ADDR_W-1:0] core_addr_in,
  input wire logic [ucpc_pkg::BE_W-1:0] core_be_n_in,
  input wire logic core_write_through_in,
  input wire logic core_cache_disable_in,
  input wire logic core_w_r_in,
  input wire logic core_d_c_in,
  input wire logic core_m_io_in,
  input wire logic core_lock_n_in,
  input wire logic core_pseudo_lock_n_in,
  input wire logic core_address_strobe_n_in,
  input wire logic core_burst_last_n_in,
  input wire logic [ucpc_pkg::DATA_W-1:0] core_data_in,
  input wire logic [ucpc_pkg::PAR_W-1:0] core_parity_in,
  input wire logic core_drive_data_in,
  // core side results
  output logic [ucpc_pkg::ADDR_W-1:0] cache_lookup_addr_out,
  output logic [ucpc_pkg::NUM_ASYNC-1:0] async_sync_out,
  output logic bus_hold_out,
  output logic address_hold_out,
  output logic external_snoop_strobe_n_out,
  output logic backoff_n_out,
  output logic bus_size_sixteen_n_out,
  output logic bus_size_eight_n_out,
  output logic cacheable_n_out,
  output logic ready_n_out,
  output logic burst_ready_n_out,
  output logic [ucpc_pkg::DATA_W-1:0] data_sample_out,
  output logic [ucpc_pkg::UPPER_W-1:0] address_snoop_out,
  // synchronous pins
  input wire logic hold_in,
  input wire logic address_hold_req_in,
  input wire logic external_snoop_strobe_n_in,
  input wire logic backoff_n_in,
  input wire logic bus_size_sixteen_n_in,
  input wire logic bus_size_eight_n_in,
  input wire logic cacheable_n_in,
  input wire logic ready_n_in,
  input wire logic burst_ready_n_in,
  // asynchronous pins
  input wire logic soft_reset_in,
  input wire logic maskable_irq_in,
  input wire logic nmi_in,
  input wire logic flush_n_in,
  input wire logic address_wrap_mask_n_in,
  input wire logic sys_mgmt_irq_n_in,
  input wire logic clock_stop_req_n_in,
  input wire logic ignore_numeric_error_n_in,
  // always driven outputs
  output logic legacy_present_n_out,
  output logic hold_acknowledge_out,
  // outputs floated in bus hold
  output logic [ucpc_pkg::BE_W-1:0] byte_enables_n_out,
  output logic page_write_through_out,
  output logic page_cache_disable_out,
  output logic w_r_out,
  output logic d_c_out,
  output logic m_io_out,
  output logic lock_n_out,
  output logic pseudo_lock_n_out,
  output logic address_strobe_n_out,
  output logic burst_last_n_out,
  output logic ctrl_oe_out,
  // address pins
  output logic [ucpc_pkg::LOW_PAIR_W-1:0] address_low_pair_out,
  input wire logic [ucpc_pkg::UPPER_W-1:0] address_upper_bits_in,
  output logic [ucpc_pkg::UPPER_W-1:0] address_upper_bits_out,
  output logic address_oe_out,
  // data pins
  input wire logic [ucpc_pkg::DATA_W-1:0] data_lines_in,
  output logic [ucpc_pkg::DATA_W-1:0] data_lines_out,
  input wire logic [ucpc_pkg::PAR_W-1:0] data_parity_lines_in,
  output logic [ucpc_pkg::PAR_W-1:0] data_parity_lines_out,
  output logic data_oe_out
);
  import ucpc_pkg::*;

  ucpc_state_s st;
  ucpc_state_s next_st;
  logic wrap_n;

  // ==========================================================
  // wrap masking, shared by cache lookup and bus cycle paths
  function automatic logic [ADDR_W-1:0] wrap_addr(input logic [ADDR_W-1:0] a,
                                                  input logic mask_n);
    logic [ADDR_W-1:0] r;
    r = a;
    if (!mask_n) begin
      r[WRAP_IDX] = 1'b0;
    end
    return r;
  endfunction

  // ==========================================================
  // asynchronous inputs
  ucpc_sync u_sync (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .async_in({ignore_numeric_error_n_in, clock_stop_req_n_in, sys_mgmt_irq_n_in,
               address_wrap_mask_n_in, flush_n_in, nmi_in, maskable_irq_in,
               soft_reset_in}),
    .sync_out(async_sync_out)
  );

  // level is re-read every clock once synchronised
  assign wrap_n = async_sync_out[AS_WRAP_N];

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    // synchronous pins are in the bus clock domain, one sample register only
    next_st.bus_hold = hold_in;
    next_st.addr_hold = address_hold_req_in;
    next_st.snoop_n = external_snoop_strobe_n_in;
    next_st.backoff_n = backoff_n_in;
    next_st.size_sixteen_n = bus_size_sixteen_n_in;
    next_st.size_eight_n = bus_size_eight_n_in;
    next_st.cacheable_n = cacheable_n_in;
    next_st.ready_n = ready_n_in;
    next_st.burst_ready_n = burst_ready_n_in;
    next_st.cache_addr = wrap_addr(core_addr_in, wrap_n);
    // io cycles are not memory cycles and keep bit 20
    next_st.bus_addr = core_m_io_in ? wrap_addr(core_addr_in, wrap_n) : core_addr_in;
    next_st.be_n = core_be_n_in;
    // page attributes registered in the same stage as cycle definition
    next_st.write_through = core_write_through_in;
    next_st.cache_disable = core_cache_disable_in;
    next_st.w_r = core_w_r_in;
    next_st.d_c = core_d_c_in;
    next_st.m_io = core_m_io_in;
    next_st.lock_n = core_lock_n_in;
    next_st.pseudo_lock_n = core_pseudo_lock_n_in;
    next_st.addr_strobe_n = core_address_strobe_n_in;
    next_st.burst_last_n = core_burst_last_n_in;
    next_st.data = core_data_in;
    next_st.parity = core_parity_in;
    next_st.drive_data = core_drive_data_in;
    next_st.data_pin = data_lines_in;
    next_st.addr_pin = address_upper_bits_in;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st <= '{bus_hold: 1'b0, addr_hold: 1'b0, snoop_n: 1'b1, backoff_n: 1'b1,
              size_sixteen_n: 1'b1, size_eight_n: 1'b1, cacheable_n: 1'b1, ready_n: 1'b1,
              burst_ready_n: 1'b1, cache_addr: ADDR_RESET, bus_addr: ADDR_RESET,
              be_n: BE_N_RESET, write_through: 1'b0, cache_disable: 1'b0, w_r: 1'b0,
              d_c: 1'b0, m_io: 1'b0, lock_n: 1'b1, pseudo_lock_n: 1'b1, addr_strobe_n: 1'b1,
              burst_last_n: 1'b1, data: DATA_RESET, parity: PAR_RESET, drive_data: 1'b0,
              data_pin: DATA_RESET, addr_pin: SNOOP_RESET};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // pin drive and float control
  // present pin is a constant low, so it holds from power-up with no float path
  assign legacy_present_n_out = 1'b0;
  assign hold_acknowledge_out = st.bus_hold;
  assign ctrl_oe_out = !st.bus_hold;
  assign address_oe_out = !(st.bus_hold || st.addr_hold);
  assign data_oe_out = !st.bus_hold && st.drive_data;

  assign byte_enables_n_out = st.be_n;
  assign page_write_through_out = st.write_through;
  assign page_cache_disable_out = st.cache_disable;
  assign w_r_out = st.w_r;
  assign d_c_out = st.d_c;
  assign m_io_out = st.m_io;
  assign lock_n_out = st.lock_n;
  assign pseudo_lock_n_out = st.pseudo_lock_n;
  assign address_strobe_n_out = st.addr_strobe_n;
  assign burst_last_n_out = st.burst_last_n;
  assign address_low_pair_out = st.bus_addr[LOW_PAIR_W-1:0];
  assign address_upper_bits_out = st.bus_addr[ADDR_W-1:LOW_PAIR_W];
  assign data_lines_out = st.data;
  assign data_parity_lines_out = st.parity;

  // ==========================================================
  // core side results
  assign cache_lookup_addr_out = st.cache_addr;
  assign bus_hold_out = st.bus_hold;
  assign address_hold_out = st.addr_hold;
  assign external_snoop_strobe_n_out = st.snoop_n;
  assign backoff_n_out = st.backoff_n;
  assign bus_size_sixteen_n_out = st.size_sixteen_n;
  assign bus_size_eight_n_out = st.size_eight_n;
  assign cacheable_n_out = st.cacheable_n;
  assign ready_n_out = st.ready_n;
  assign burst_ready_n_out = st.burst_ready_n;
  // data and snooped address are sampled from the pins on the bus clock
  assign data_sample_out = st.data_pin;
  assign address_snoop_out = st.addr_pin;

  // ==========================================================
  // checks
  sequence s_wrap_low;
    !address_wrap_mask_n_in [*3];
  endsequence

  property p_cache_wrap;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      !wrap_n |=> !cache_lookup_addr_out[WRAP_IDX];
  endproperty
  a_cache_wrap: assert property (p_cache_wrap) else $error("cache bit 20 not masked");

  property p_bus_wrap;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      !wrap_n && core_m_io_in |=> !address_upper_bits_out[WRAP_IDX-LOW_PAIR_W] && m_io_out;
  endproperty
  a_bus_wrap: assert property (p_bus_wrap) else $error("bus bit 20 not masked");

  property p_wrap_level;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      s_wrap_low |=> !cache_lookup_addr_out[WRAP_IDX];
  endproperty
  a_wrap_level: assert property (p_wrap_level) else $error("held wrap level not seen");

  property p_present;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      legacy_present_n_out == 1'b0;
  endproperty
  a_present: assert property (p_present) else $error("present pin not low");

  property p_ctrl_float;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      hold_in |=> !ctrl_oe_out && hold_acknowledge_out;
  endproperty
  a_ctrl_float: assert property (p_ctrl_float) else $error("control driven in bus hold");

  property p_addr_float;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      address_hold_req_in && !hold_in |=> !address_oe_out && ctrl_oe_out;
  endproperty
  a_addr_float: assert property (p_addr_float) else $error("address driven in hold");

  property p_data_keep;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      address_hold_req_in && !hold_in && core_drive_data_in |=> data_oe_out;
  endproperty
  a_data_keep: assert property (p_data_keep) else $error("data floated in address hold");

  property p_data_bhold;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      hold_in |=> !data_oe_out;
  endproperty
  a_data_bhold: assert property (p_data_bhold) else $error("data driven in bus hold");

  property p_sync_sample;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      ready_n_out == $past(ready_n_in) && backoff_n_out == $past(backoff_n_in);
  endproperty
  a_sync_sample: assert property (p_sync_sample) else $error("sync pin not one-clock sample");

  property p_page_timing;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      page_write_through_out == $past(core_write_through_in) &&
        page_cache_disable_out == $past(core_cache_disable_in) && w_r_out == $past(core_w_r_in);
  endproperty
  a_page_timing: assert property (p_page_timing) else $error("page pin timing differs");

  property p_async_delay;
    @(posedge core_clk_in) disable iff (!rst_b_in)
      $past(nmi_in, 2) == async_sync_out[AS_NMI];
  endproperty
  a_async_delay: assert property (p_async_delay) else $error("async input not synchronised");

endmodule // ucpc_pin_ctrl

// ### testbench/ucpc_far_side.sv
// far side model: system chipset as bus master and the original socketed processor
// assumes the bench sets its requests at falling clock edges
`timescale 1ns/10ps
module ucpc_far_side (
  // bench requests
  input wire logic rst_b_in,
  input wire logic real_mode_in,
  input wire logic want_wrap_in,
  input wire logic want_hold_in,
  input wire logic want_ah_in,
  input wire logic [ucpc_pkg::DATA_W-1:0] snoop_data_in,
  input wire logic [ucpc_pkg::UPPER_W-1:0] snoop_addr_in,
  // device pins
  input wire logic legacy_present_n_in,
  input wire logic address_oe_in,
  input wire logic data_oe_in,
  input wire logic [ucpc_pkg::UPPER_W-1:0] dev_addr_in,
  input wire logic [ucpc_pkg::DATA_W-1:0] dev_data_in,
  output logic hold_out,
  output logic address_hold_out,
  output logic address_wrap_mask_n_out,
  output logic [ucpc_pkg::UPPER_W-1:0] addr_wire_out,
  output logic [ucpc_pkg::DATA_W-1:0] data_wire_out,
  output logic orig_floated_out
);
  import ucpc_pkg::*;
  // ==========================================================
  // requests
  // no hold while reset is low, so the device starts on a quiet bus
  assign hold_out = rst_b_in & want_hold_in;
  assign address_hold_out = rst_b_in & want_ah_in;
  // wrap stays high through reset and is only asked for in real mode
  assign address_wrap_mask_n_out = !(rst_b_in & real_mode_in & want_wrap_in);
  // ==========================================================
  // wires: whenever the device floats, the system master drives them
  assign addr_wire_out = address_oe_in ? dev_addr_in : snoop_addr_in;
  assign data_wire_out = data_oe_in ? dev_data_in : snoop_data_in;
  // the original processor leaves the bus once present is low
  assign orig_floated_out = !legacy_present_n_in;
endmodule // ucpc_far_side

// ### testbench/ucpc_pin_ctrl_tb.sv
// bench for the upgrade cpu pin control block
// assumes the far side model drives hold, address hold, wrap mask and the shared wires
`timescale 1ns/10ps
module ucpc_pin_ctrl_tb;
  import ucpc_pkg::*;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] c_addr = 30'h0;
  logic [BE_W-1:0] c_be_n = 4'hF;
  logic [8:0] c_ctl = 9'h0F;
  logic [DATA_W-1:0] c_data = 32'h0;
  logic [PAR_W-1:0] c_par = 4'h3;
  logic c_drv = 1'b0;
  logic [6:0] spin = 7'h7F;
  logic [7:0] apin = 8'hF8;
  logic real_mode = 1'b0, want_wrap = 1'b0, want_hold = 1'b0, want_ah = 1'b0;
  logic [DATA_W-1:0] snp_data = 32'h5A3CF069;
  logic [UPPER_W-1:0] snp_addr = 28'h0F0F0F0;
  wire hold, a_hold, wrap_n, present_n, hold_ack, ctrl_oe, addr_oe, data_oe, orig_off;
  wire [UPPER_W-1:0] a_wire, a_out, a_snp;
  wire [DATA_W-1:0] d_wire, d_out, d_smp;
  wire [PAR_W-1:0] p_wire, p_out;
  wire [ADDR_W-1:0] look;
  wire [7:0] a_sync;
  wire [8:0] s_smp, o_ctl;
  wire [BE_W-1:0] o_be_n;
  wire [1:0] o_low;
  int n_errors = 0;
  int checked = 0;
  // a released parity line shows the inverse of its last value
  assign p_wire = data_oe ? p_out : ~p_out;
  always #50 clk = ~clk;
  // ==========================================================
  // design and far side
  ucpc_pin_ctrl dut_u (
    .core_clk_in(clk), .rst_b_in(rst_b), .core_addr_in(c_addr), .core_be_n_in(c_be_n),
    .core_write_through_in(c_ctl[8]), .core_cache_disable_in(c_ctl[7]), .core_w_r_in(c_ctl[6]),
    .core_d_c_in(c_ctl[5]), .core_m_io_in(c_ctl[4]), .core_lock_n_in(c_ctl[3]),
    .core_pseudo_lock_n_in(c_ctl[2]), .core_address_strobe_n_in(c_ctl[1]),
    .core_burst_last_n_in(c_ctl[0]),
    .core_data_in(c_data), .core_parity_in(c_par), .core_drive_data_in(c_drv),
    .cache_lookup_addr_out(look), .async_sync_out(a_sync), .bus_hold_out(s_smp[8]),
    .address_hold_out(s_smp[7]), .external_snoop_strobe_n_out(s_smp[6]),
    .backoff_n_out(s_smp[5]), .bus_size_sixteen_n_out(s_smp[4]),
    .bus_size_eight_n_out(s_smp[3]), .cacheable_n_out(s_smp[2]), .ready_n_out(s_smp[1]),
    .burst_ready_n_out(s_smp[0]), .data_sample_out(d_smp), .address_snoop_out(a_snp),
    .hold_in(hold), .address_hold_req_in(a_hold), .external_snoop_strobe_n_in(spin[6]),
    .backoff_n_in(spin[5]), .bus_size_sixteen_n_in(spin[4]), .bus_size_eight_n_in(spin[3]),
    .cacheable_n_in(spin[2]), .ready_n_in(spin[1]), .burst_ready_n_in(spin[0]),
    .soft_reset_in(apin[0]), .maskable_irq_in(apin[1]), .nmi_in(apin[2]),
    .flush_n_in(apin[3]), .address_wrap_mask_n_in(wrap_n), .sys_mgmt_irq_n_in(apin[5]),
    .clock_stop_req_n_in(apin[6]), .ignore_numeric_error_n_in(apin[7]),
    .legacy_present_n_out(present_n), .hold_acknowledge_out(hold_ack),
    .byte_enables_n_out(o_be_n), .page_write_through_out(o_ctl[8]),
    .page_cache_disable_out(o_ctl[7]), .w_r_out(o_ctl[6]), .d_c_out(o_ctl[5]),
    .m_io_out(o_ctl[4]), .lock_n_out(o_ctl[3]), .pseudo_lock_n_out(o_ctl[2]),
    .address_strobe_n_out(o_ctl[1]), .burst_last_n_out(o_ctl[0]), .ctrl_oe_out(ctrl_oe),
    .address_low_pair_out(o_low), .address_upper_bits_in(a_wire),
    .address_upper_bits_out(a_out), .address_oe_out(addr_oe), .data_lines_in(d_wire),
    .data_lines_out(d_out), .data_parity_lines_in(p_wire), .data_parity_lines_out(p_out),
    .data_oe_out(data_oe)
  );
  ucpc_far_side far_u (
    .rst_b_in(rst_b), .real_mode_in(real_mode), .want_wrap_in(want_wrap),
    .want_hold_in(want_hold), .want_ah_in(want_ah), .snoop_data_in(snp_data),
    .snoop_addr_in(snp_addr), .legacy_present_n_in(present_n), .address_oe_in(addr_oe),
    .data_oe_in(data_oe), .dev_addr_in(a_out), .dev_data_in(d_out), .hold_out(hold),
    .address_hold_out(a_hold), .address_wrap_mask_n_out(wrap_n), .addr_wire_out(a_wire),
    .data_wire_out(d_wire), .orig_floated_out(orig_off)
  );
  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    check("present", 32'h0, 32'(present_n));
    check("async idle", 32'hF8, 32'(a_sync));
    check("orig off", 32'h1, 32'(orig_off));
    check("oe", 32'h6, 32'({ctrl_oe, addr_oe, data_oe}));
    $display("test reset done");
  endtask
  task automatic t_pass();
    c_be_n = 4'h5;
    c_ctl = 9'h1A5;
    c_addr = 30'h2;
    step(1);
    check("be", 32'h5, 32'(o_be_n));
    check("cycle", 32'h1A5, 32'(o_ctl));
    check("low pair", 32'h2, 32'(o_low));
    c_ctl = 9'h05A;
    step(1);
    check("cycle", 32'h05A, 32'(o_ctl));
    $display("test pass done");
  endtask
  task automatic t_wrap();
    logic [ADDR_W-1:0] a;
    a = 30'h3FFFFFFF;
    real_mode = 1'b1;
    want_wrap = 1'b1;
    step(1);
    check("wrap early", 32'h1, 32'(a_sync[AS_WRAP_N]));
    step(1);
    check("wrap sync", 32'h0, 32'(a_sync[AS_WRAP_N]));
    c_addr = a;
    c_ctl[4] = 1'b1;
    step(1);
    check("lookup", 32'(a & ~(30'h1 << WRAP_IDX)), 32'(look));
    check("bus addr", 32'(a[ADDR_W-1:2] & ~(28'h1 << (WRAP_IDX - 2))), 32'(a_out));
    c_ctl[4] = 1'b0;
    step(1);
    check("io lookup", 32'(a & ~(30'h1 << WRAP_IDX)), 32'(look));
    check("io bus addr", 32'(a[ADDR_W-1:2]), 32'(a_out));
    want_wrap = 1'b0;
    step(3);
    check("unmasked", 32'(a), 32'(look));
    real_mode = 1'b0;
    $display("test wrap done");
  endtask
  task automatic t_sync();
    // walking zero, one new pattern every clock
    for (int i = 0; i < 7; i++) begin
      spin = ~(7'h1 << i);
      step(1);
      check("sync pins", 32'({2'b00, ~(7'h1 << i)}), 32'(s_smp));
    end
    spin = 7'h7F;
    $display("test sync done");
  endtask
  task automatic t_async();
    for (int i = 0; i < NUM_ASYNC; i++) begin
      if (i != AS_WRAP_N) begin
        apin = ASYNC_RESET ^ (8'h1 << i);
        step(1);
        check("async early", 32'(ASYNC_RESET), 32'(a_sync));
        step(1);
        check("async", 32'(apin), 32'(a_sync));
        apin = ASYNC_RESET;
        step(2);
      end
    end
    $display("test async done");
  endtask
  task automatic t_hold();
    c_drv = 1'b1;
    c_data = 32'hA5C30F96;
    step(2);
    check("data out", 32'hA5C30F96, d_smp);
    check("data pins", 32'hA5C30F96, d_out);
    check("parity pins", 32'h3, 32'(p_out));
    want_hold = 1'b1;
    step(1);
    check("hold ack", 32'h1, 32'(hold_ack));
    check("hold oe", 32'h0, 32'({ctrl_oe, addr_oe, data_oe}));
    check("present", 32'h0, 32'(present_n));
    step(1);
    check("hold data", 32'h5A3CF069, d_smp);
    check("hold addr", 32'(snp_addr), 32'(a_snp));
    want_hold = 1'b0;
    want_ah = 1'b1;
    step(1);
    check("addr hold oe", 32'h5, 32'({ctrl_oe, addr_oe, data_oe}));
    step(1);
    check("addr hold data", 32'hA5C30F96, d_smp);
    check("addr hold addr", 32'(snp_addr), 32'(a_snp));
    want_ah = 1'b0;
    step(1);
    check("free oe", 32'h7, 32'({ctrl_oe, addr_oe, data_oe}));
    $display("test hold done");
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk);
    t_reset();
    @(negedge clk);
    rst_b = 1'b1;
    step(2);
    t_pass();
    t_wrap();
    t_sync();
    t_async();
    t_hold();
    results();
  end
  // the tests need under a hundred clocks; this leaves wide room
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    results();
  end
endmodule // ucpc_pin_ctrl_tb
